// *** ocp_pkg.sv ***
// Purpose: constants and types for the two-stage overcurrent decision logic
// Assumes: currents arrive as unsigned samples in a common scale
// Notes: register map on APB, one aligned 32-bit word each
package ocp_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int CUR_W = 16;
  localparam int TIM_W = 32;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LOW_THR = 8'h04;
  localparam logic [7:0] REG_HIGH_THR = 8'h08;
  localparam logic [7:0] REG_LOW_TIME = 8'h0C;
  localparam logic [7:0] REG_HIGH_TIME = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_CMD = 8'h18;
  // Control register fields
  localparam int CTRL_SG1_LSB = 0;
  localparam int CTRL_SG2_LSB = 8;
  localparam int CTRL_SGB_LSB = 16;
  localparam int CTRL_HINF_BIT = 24;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LOW_THR_RST = 32'h0000_FFFF;
  localparam logic [31:0] HIGH_THR_RST = 32'h0000_FFFF;
  localparam logic [31:0] LOW_TIME_RST = 32'h0000_0064;
  localparam logic [31:0] HIGH_TIME_RST = 32'h0000_0064;
  // Command register: bit0 first clear command, bit1 second clear command
  localparam int CMD_CLR_A_BIT = 0;
  localparam int CMD_CLR_B_BIT = 1;
  // Time base: one tick per millisecond
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int INRUSH_MS = 60;
  localparam int INRUSH_TICKS = INRUSH_MS / TICK_MS;
  // Inrush ratios in sixty-fourths: 0.12 -> 8/64 rounded, 3.0, 2.0
  localparam int RATIO_LOW_X64 = 8;
  localparam int RATIO_ON_X64 = 192;
  localparam int RATIO_OFF_X64 = 128;
  // Range multipliers applied to delay setting (ms per step)
  localparam int RANGE_X1 = 1;
  localparam int RANGE_X10 = 10;
  localparam int RANGE_X100 = 100;

  typedef struct packed {
    logic [CUR_W-1:0] ph3;
    logic [CUR_W-1:0] ph2;
    logic [CUR_W-1:0] ph1;
  } ocp_cur_t;

  typedef struct packed {
    logic start;
    logic trip;
  } ocp_stage_t;

  typedef enum logic [1:0] {
    OCP_IND_OFF,
    OCP_IND_YELLOW,
    OCP_IND_RED
  } ocp_ind_t;
endpackage : ocp_pkg

// *** ocp_stage.sv ***
// Purpose: one overcurrent stage: compare, time, start and trip
// Assumes: tick is a one-cycle pulse per millisecond
// Notes: trip latching and indicators live in the top module
`timescale 1ns/1ns
`default_nettype none
module ocp_stage
  import ocp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire ocp_cur_t cur,
  input wire logic [CUR_W:0] thr,
  input wire logic block,
  input wire logic [TIM_W-1:0] delay_ticks,
  output ocp_stage_t st
);
  logic over;
  logic [TIM_W-1:0] cnt;

  assign over = !block && (({1'b0, cur.ph1} > thr) ||
    ({1'b0, cur.ph2} > thr) || ({1'b0, cur.ph3} > thr));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= '0;
    else if (!over)
      cnt <= '0;
    else if (tick && cnt < delay_ticks)
      cnt <= cnt + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
    begin
      st.start <= over;
      st.trip <= over && cnt >= delay_ticks;
    end
  end
endmodule : ocp_stage
`default_nettype wire

// *** ocp_top.sv ***
// Purpose: two-stage phase overcurrent decision logic with APB registers
// Assumes: phase currents synchronous to sys_clk, unsigned magnitudes
// Notes: inverse curve formulas are approximated by a scaled delay
`timescale 1ns/1ns
`default_nettype none
module ocp_top
  import ocp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CUR_W-1:0] phase_current_1,
  input wire logic [CUR_W-1:0] phase_current_2,
  input wire logic [CUR_W-1:0] phase_current_3,
  input wire logic external_block_line_1,
  input wire logic external_block_line_2,
  input wire logic external_block_line_3,
  input wire logic reset_button,
  input wire logic step_button,
  output logic low_stage_start_out,
  output logic high_stage_start_out,
  output logic low_stage_trip_out,
  output logic high_stage_trip_out,
  output logic autoreclose_start_1,
  output logic autoreclose_start_2,
  output ocp_ind_t low_indicator,
  output ocp_ind_t high_indicator
);
  // ==========================================================
  // Reset release
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ==========================================================
  // Registers
  logic [31:0] ctrl, low_thr_reg, high_thr_reg, low_time, high_time;
  logic [7:0] front_switch_group, indicator_mode_switches;
  logic [7:0] board_block_select_switches;
  logic high_infinite;
  logic wr, rd, clr_cmd;
  logic [31:0] status;

  assign front_switch_group = ctrl[CTRL_SG1_LSB +: 8];
  assign indicator_mode_switches = ctrl[CTRL_SG2_LSB +: 8];
  assign board_block_select_switches = ctrl[CTRL_SGB_LSB +: 8];
  assign high_infinite = ctrl[CTRL_HINF_BIT];
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign pready = 1'b1;
  assign clr_cmd = wr && paddr == REG_CMD &&
    (pwdata[CMD_CLR_A_BIT] || pwdata[CMD_CLR_B_BIT]);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= CTRL_RST;
      low_thr_reg <= LOW_THR_RST;
      high_thr_reg <= HIGH_THR_RST;
      low_time <= LOW_TIME_RST;
      high_time <= HIGH_TIME_RST;
    end
    else if (wr)
    begin
      case (paddr)
        REG_CTRL: ctrl <= pwdata;
        REG_LOW_THR: low_thr_reg <= pwdata;
        REG_HIGH_THR: high_thr_reg <= pwdata;
        REG_LOW_TIME: low_time <= pwdata;
        REG_HIGH_TIME: high_time <= pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= 1'b0;
      if (rd && !penable)
      begin
        case (paddr)
          REG_CTRL: prdata <= ctrl;
          REG_LOW_THR: prdata <= low_thr_reg;
          REG_HIGH_THR: prdata <= high_thr_reg;
          REG_LOW_TIME: prdata <= low_time;
          REG_HIGH_TIME: prdata <= high_time;
          REG_STATUS: prdata <= status;
          REG_CMD: prdata <= 32'h0000_0000;
          default: prdata <= 32'h0000_0000;
        endcase
      end
      if (psel && !penable)
        pslverr <= paddr > REG_CMD || paddr[1:0] != 2'b00;
    end
  end

  // ==========================================================
  // Millisecond tick
  logic [15:0] tick_cnt;
  logic tick;
  assign tick = tick_cnt == 16'(TICK_CYC - 1);
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt <= 16'h0000;
    else if (tick)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  // ==========================================================
  // Blocking and autoreclose routing
  ocp_cur_t cur;
  logic [2:0] ext;
  logic low_stage_block_in, high_stage_block_in;
  ocp_stage_t low_st, high_st;
  assign cur = '{ph3: phase_current_3, ph2: phase_current_2,
    ph1: phase_current_1};
  assign ext = {external_block_line_3, external_block_line_2,
    external_block_line_1};
  assign low_stage_block_in =
    |(ext & board_block_select_switches[2:0]);
  assign high_stage_block_in =
    |(ext & board_block_select_switches[5:3]);
  assign autoreclose_start_1 = board_block_select_switches[6] ?
    high_st.start : low_st.start;
  assign autoreclose_start_2 = board_block_select_switches[7] ?
    high_st.start : low_st.start;

  // ==========================================================
  // Inrush detection
  logic [CUR_W-1:0] max_cur;
  logic [CUR_W+7:0] max_x64, lthr_x64;
  logic below_low, above_on, below_off;
  logic armed, inrush, inrush_now;
  logic [7:0] win;
  always_comb
  begin
    max_cur = phase_current_1;
    if (phase_current_2 > max_cur)
      max_cur = phase_current_2;
    if (phase_current_3 > max_cur)
      max_cur = phase_current_3;
  end
  assign max_x64 = {max_cur, 6'b0} + (CUR_W+8)'(0);
  assign lthr_x64 = {8'h00, low_thr_reg[CUR_W-1:0]};
  assign below_low = max_x64 < (CUR_W+8)'(lthr_x64 * RATIO_LOW_X64);
  assign above_on = max_x64 > (CUR_W+8)'(lthr_x64 * RATIO_ON_X64);
  assign below_off = max_x64 < (CUR_W+8)'(lthr_x64 * RATIO_OFF_X64);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed <= 1'b0;
      win <= 8'h00;
    end
    else if (below_low)
    begin
      armed <= 1'b1;
      win <= 8'h00;
    end
    else if (armed && tick)
    begin
      win <= win + 8'h01;
      if (win >= 8'(INRUSH_TICKS - 1))
        armed <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      inrush <= 1'b0;
    else if (armed && above_on)
      inrush <= 1'b1;
    else if (below_off)
      inrush <= 1'b0;
  end
  // Look-ahead: without it the high stage sees one undoubled cycle
  assign inrush_now = (armed && above_on) || (inrush && !below_off);

  // ==========================================================
  // Thresholds and delays
  logic [CUR_W:0] low_thr, high_thr;
  logic [1:0] lrange, hrange;
  logic [TIM_W-1:0] low_delay, high_delay;
  logic [TIM_W-1:0] low_step, high_step;
  assign low_thr = {1'b0, low_thr_reg[CUR_W-1:0]};
  // Switch 6 picks scale of the high setting: range 2.5-20 or 0.5-4.0
  always_comb
  begin
    if (high_infinite)
      high_thr = {1'b1, {CUR_W{1'b1}}};
    else if (front_switch_group[5])
      high_thr = {1'b0, high_thr_reg[CUR_W-1:0]};
    else
      high_thr = {1'b0, high_thr_reg[CUR_W-1:0]} * 17'd5;
    if (front_switch_group[4] && inrush_now && !high_infinite)
      high_thr = {high_thr[CUR_W-1:0], 1'b0};
  end

  assign lrange = front_switch_group[1:0];
  assign hrange = front_switch_group[7:6];
  always_comb
  begin
    case (hrange)
      2'b00: high_step = TIM_W'(RANGE_X1);
      2'b01: high_step = TIM_W'(RANGE_X10);
      default: high_step = TIM_W'(RANGE_X100);
    endcase
    if (front_switch_group[2])
      // Curve groups as scale factors; true inverse shape left out
      case (lrange)
        2'b00: low_step = TIM_W'(RANGE_X1);
        2'b01: low_step = TIM_W'(RANGE_X1 * 2);
        2'b10: low_step = TIM_W'(RANGE_X10);
        default: low_step = TIM_W'(RANGE_X10 * 2);
      endcase
    else
      case (lrange)
        2'b00: low_step = TIM_W'(RANGE_X1);
        2'b01: low_step = TIM_W'(RANGE_X10);
        default: low_step = TIM_W'(RANGE_X100);
      endcase
  end
  assign low_delay = TIM_W'(low_time[15:0] * low_step[15:0]);
  assign high_delay = TIM_W'(high_time[15:0] * high_step[15:0]);

  ocp_stage u_low (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick),
    .cur(cur),
    .thr(low_thr),
    .block(low_stage_block_in),
    .delay_ticks(low_delay),
    .st(low_st)
  );
  ocp_stage u_high (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick),
    .cur(cur),
    .thr(high_thr),
    .block(high_stage_block_in),
    .delay_ticks(high_delay),
    .st(high_st)
  );

  // ==========================================================
  // Outputs, latching and indicators
  logic low_trip_l, high_trip_l, trip_clr, ind_clr;
  logic [3:0] ind_hold;
  logic [3:0] ind_src;
  assign trip_clr = clr_cmd || (reset_button && step_button);
  assign ind_clr = clr_cmd || reset_button;
  assign low_stage_start_out = low_st.start;
  assign high_stage_start_out = high_st.start;
  assign low_stage_trip_out = low_st.trip || low_trip_l;
  assign high_stage_trip_out = high_st.trip || high_trip_l;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_trip_l <= 1'b0;
      high_trip_l <= 1'b0;
    end
    else
    begin
      // Set beats clear so a new trip is never lost
      low_trip_l <= front_switch_group[3] &&
        (low_st.trip || (low_trip_l && !trip_clr));
      high_trip_l <= front_switch_group[3] &&
        (high_st.trip || (high_trip_l && !trip_clr));
    end
  end

  assign ind_src = {high_st.trip, high_st.start, low_st.trip, low_st.start};
  // Order: low start, low trip, high start, high trip
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ind
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          ind_hold[gi] <= 1'b0;
        else if (ind_src[gi])
          ind_hold[gi] <= 1'b1;
        else if (ind_clr)
          ind_hold[gi] <= 1'b0;
        else if (!indicator_mode_switches[gi] && (gi % 2) == 0)
          ind_hold[gi] <= 1'b0;
      end
    end
  endgenerate

  // Red trip memory persists until cleared; protection never waits on it
  always_comb
  begin
    if (ind_hold[1])
      low_indicator = OCP_IND_RED;
    else if (ind_hold[0])
      low_indicator = OCP_IND_YELLOW;
    else
      low_indicator = OCP_IND_OFF;
    if (ind_hold[3])
      high_indicator = OCP_IND_RED;
    else if (ind_hold[2])
      high_indicator = OCP_IND_YELLOW;
    else
      high_indicator = OCP_IND_OFF;
  end

  assign status = {21'h00000, inrush, high_indicator, low_indicator,
    high_stage_trip_out, low_stage_trip_out, high_st.start, low_st.start,
    high_stage_block_in, low_stage_block_in};

  // ==========================================================
  // Checks
  property p_start_follows;
    @(posedge sys_clk) disable iff (!rst_n)
      (!low_stage_block_in && phase_current_1 > low_thr_reg[CUR_W-1:0] &&
       $stable(low_stage_block_in)) |=> low_stage_start_out;
  endproperty
  a_start_follows: assert property (p_start_follows)
    else $error("low start missing");
  property p_block_low;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(low_stage_block_in) |-> !low_st.start;
  endproperty
  a_block_low: assert property (p_block_low)
    else $error("blocked low stage started");
  property p_block_high;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(high_stage_block_in) |-> !high_st.start;
  endproperty
  a_block_high: assert property (p_block_high)
    else $error("blocked high stage started");
  property p_trip_red;
    @(posedge sys_clk) disable iff (!rst_n)
      low_st.trip |=> low_indicator == OCP_IND_RED;
  endproperty
  a_trip_red: assert property (p_trip_red)
    else $error("trip without red");
  property p_red_stays;
    @(posedge sys_clk) disable iff (!rst_n)
      (low_indicator == OCP_IND_RED && !ind_clr) |=>
        low_indicator == OCP_IND_RED;
  endproperty
  a_red_stays: assert property (p_red_stays)
    else $error("red dropped without clear");
  property p_latch;
    @(posedge sys_clk) disable iff (!rst_n)
      (front_switch_group[3] && low_stage_trip_out && !trip_clr &&
       $stable(front_switch_group)) |=> low_stage_trip_out;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched trip fell");
  property p_inf;
    @(posedge sys_clk) disable iff (!rst_n)
      high_infinite [*2] |-> !high_st.start;
  endproperty
  a_inf: assert property (p_inf)
    else $error("infinite high stage started");
  property p_drop;
    @(posedge sys_clk) disable iff (!rst_n)
      !low_stage_start_out |-> !low_st.trip;
  endproperty
  a_drop: assert property (p_drop)
    else $error("trip without start");
  property p_inrush_end;
    @(posedge sys_clk) disable iff (!rst_n)
      (below_off && !(armed && above_on)) |=> !inrush;
  endproperty
  a_inrush_end: assert property (p_inrush_end)
    else $error("inrush held below 2x");
  c_low_trip: cover property (@(posedge sys_clk) low_stage_trip_out);
  c_high_trip: cover property (@(posedge sys_clk) high_stage_trip_out);
  c_inrush: cover property (@(posedge sys_clk) inrush);
endmodule : ocp_top
`default_nettype wire

// *** ocp_far_model.sv ***
// Purpose: far-side model: phase current samples and blocking lines
// Assumes: samples change only just after a rising clock edge
// Notes: the bench steers it through the drive task
`timescale 1ns/1ns
`default_nettype none
module ocp_far_model
  import ocp_pkg::*;
(
  input wire logic sys_clk,
  output logic [CUR_W-1:0] phase_current_1,
  output logic [CUR_W-1:0] phase_current_2,
  output logic [CUR_W-1:0] phase_current_3,
  output logic [2:0] block_lines
);
  initial
  begin
    phase_current_1 = '0;
    phase_current_2 = '0;
    phase_current_3 = '0;
    block_lines = 3'h0;
  end

  // New sample set lands on one edge, like a real measuring front end
  task drive(input logic [CUR_W-1:0] a, b, c, input logic [2:0] k);
    @(posedge sys_clk);
    phase_current_1 <= a;
    phase_current_2 <= b;
    phase_current_3 <= c;
    block_lines <= k;
  endtask : drive
endmodule : ocp_far_model
`default_nettype wire

// *** two_stage_overcurrent_logic_tb.sv ***
// Purpose: self-checking bench for the overcurrent decision logic
// Assumes: 1 ms tick, so delays that must expire are kept at 0 or 1 ms
// Notes: registers reached over APB, currents from the far model
`timescale 1ns/1ns
`default_nettype none
module two_stage_overcurrent_logic_tb
  import ocp_pkg::*;
;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic reset_button = 1'b0;
  logic step_button = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, ls, hs, lt, ht, ar1, ar2;
  logic [CUR_W-1:0] c1, c2, c3;
  logic [2:0] blk;
  ocp_ind_t li, hi;
  int n_errors = 0;
  int comparisons = 0;
  int k;

  always #20 sys_clk = ~sys_clk;

  ocp_far_model i_far (.sys_clk, .phase_current_1(c1),
    .phase_current_2(c2), .phase_current_3(c3), .block_lines(blk));

  ocp_top i_dut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .phase_current_1(c1),
    .phase_current_2(c2), .phase_current_3(c3),
    .external_block_line_1(blk[0]), .external_block_line_2(blk[1]),
    .external_block_line_3(blk[2]), .reset_button, .step_button,
    .low_stage_start_out(ls), .high_stage_start_out(hs),
    .low_stage_trip_out(lt), .high_stage_trip_out(ht),
    .autoreclose_start_1(ar1), .autoreclose_start_2(ar2),
    .low_indicator(li), .high_indicator(hi));

  // ==========================================================
  // Compare and report
  task chk1(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask : chk1

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: read got %h exp %h", $time, got, exp);
    end
  endtask : chk32

  task chkind(input ocp_ind_t got, input ocp_ind_t exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: indicator got %0d", $time, got);
    end
  endtask : chkind

  task wrap_up;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // ==========================================================
  // APB master and helpers
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk32(r, x);
    chk1(e, xe, "slave error");
  endtask : rdchk

  task settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle

  task cur(input logic [CUR_W-1:0] a, b, c, input logic [2:0] bk);
    i_far.drive(a, b, c, bk);
    settle(4);
  endtask : cur

  task press(input logic stp);
    @(posedge sys_clk);
    reset_button <= 1'b1;
    step_button <= stp;
    repeat (2) @(posedge sys_clk);
    reset_button <= 1'b0;
    step_button <= 1'b0;
    settle(2);
  endtask : press

  // ==========================================================
  // Watchdog
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    $display("unexpected at %0t: run took too long", $time);
    wrap_up();
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdchk(REG_CTRL, CTRL_RST, 1'b0);
    rdchk(REG_LOW_THR, LOW_THR_RST, 1'b0);
    rdchk(REG_HIGH_THR, HIGH_THR_RST, 1'b0);
    rdchk(REG_LOW_TIME, LOW_TIME_RST, 1'b0);
    rdchk(REG_HIGH_TIME, HIGH_TIME_RST, 1'b0);
    rdchk(8'h40, 32'h0, 1'b1);
    // Start, delayed trip, red memory
    wr(REG_CTRL, 32'h0000_0020);
    wr(REG_LOW_THR, 32'h0000_0064);
    wr(REG_HIGH_THR, 32'h0000_03E8);
    wr(REG_LOW_TIME, 32'h0000_0001);
    wr(REG_HIGH_TIME, 32'h0000_0000);
    cur(16'h0000, 16'h0096, 16'h0000, 3'h0);
    chk1(ls, 1'b1, "low start");
    chk1(hs, 1'b0, "high start");
    chk1(lt, 1'b0, "low trip early");
    chkind(li, OCP_IND_YELLOW);
    for (k = 0; k < 60000 && lt !== 1'b1; k++) @(posedge sys_clk);
    settle(2);
    chk1(lt, 1'b1, "low trip");
    chkind(li, OCP_IND_RED);
    cur(16'h0000, 16'h0000, 16'h0000, 3'h0);
    chk1(ls, 1'b0, "low start drop");
    chk1(lt, 1'b0, "low trip self reset");
    chkind(li, OCP_IND_RED);
    wr(REG_CMD, 32'h0000_0001);
    settle(2);
    chkind(li, OCP_IND_OFF);
    // Latching start indication, abandoned timing
    wr(REG_CTRL, 32'h0000_0120);
    wr(REG_LOW_TIME, 32'h0000_0064);
    cur(16'h0000, 16'h0000, 16'h0096, 3'h0);
    chk1(ls, 1'b1, "low start ph3");
    cur(16'h0000, 16'h0000, 16'h0000, 3'h0);
    chk1(ls, 1'b0, "start abandon");
    chk1(lt, 1'b0, "trip abandon");
    chkind(li, OCP_IND_YELLOW);
    press(1'b0);
    chkind(li, OCP_IND_OFF);
    // Latched trip outputs
    wr(REG_CTRL, 32'h0000_0028);
    wr(REG_LOW_TIME, 32'h0000_0000);
    cur(16'h0096, 16'h0000, 16'h0000, 3'h0);
    cur(16'h0000, 16'h0000, 16'h0000, 3'h0);
    chk1(lt, 1'b1, "trip latched");
    press(1'b1);
    chk1(lt, 1'b0, "trip released by buttons");
    cur(16'h0096, 16'h0000, 16'h0000, 3'h0);
    cur(16'h0000, 16'h0000, 16'h0000, 3'h0);
    chk1(lt, 1'b1, "trip latched again");
    wr(REG_CMD, 32'h0000_0002);
    settle(2);
    chk1(lt, 1'b0, "trip released by command");
    // Blocking and autoreclose routing
    wr(REG_HIGH_THR, 32'h0000_00C8);
    wr(REG_CTRL, 32'h0051_0020);
    cur(16'h0096, 16'h0000, 16'h0000, 3'h0);
    chk1(ar1, 1'b0, "autoreclose 1");
    chk1(ar2, 1'b1, "autoreclose 2");
    cur(16'h012C, 16'h0000, 16'h0000, 3'h1);
    chk1(lt, 1'b0, "low blocked");
    chk1(ht, 1'b1, "high free");
    chk1(ar1, 1'b1, "autoreclose 1 high");
    chkind(hi, OCP_IND_RED);
    rdchk(REG_STATUS, 32'h0000_02A9, 1'b0);
    cur(16'h012C, 16'h0000, 16'h0000, 3'h2);
    chk1(lt, 1'b1, "low free");
    chk1(ht, 1'b0, "high blocked");
    // Infinite high threshold
    wr(REG_CTRL, 32'h0100_0020);
    cur(16'h1388, 16'h1388, 16'h1388, 3'h0);
    chk1(hs, 1'b0, "high start inf");
    chk1(ht, 1'b0, "high trip inf");
    chk1(lt, 1'b1, "low trip while unreset");
    // High threshold range
    wr(REG_CTRL, 32'h0000_0000);
    cur(16'h01F4, 16'h0000, 16'h0000, 3'h0);
    chk1(hs, 1'b0, "high wide range");
    wr(REG_CTRL, 32'h0000_0020);
    settle(4);
    chk1(hs, 1'b1, "high low range");
    // Inrush doubling
    wr(REG_HIGH_THR, 32'h0000_0190);
    wr(REG_CTRL, 32'h0000_0030);
    cur(16'h0000, 16'h0000, 16'h0000, 3'h0);
    cur(16'h01F4, 16'h0000, 16'h0000, 3'h0);
    chk1(hs, 1'b0, "high doubled");
    cur(16'h0096, 16'h0000, 16'h0000, 3'h0);
    // Stay under 3x so the still-armed window cannot retrigger
    wr(REG_HIGH_THR, 32'h0000_00B4);
    cur(16'h00FA, 16'h0000, 16'h0000, 3'h0);
    chk1(hs, 1'b1, "inrush over");
    wrap_up();
  end
endmodule : two_stage_overcurrent_logic_tb
`default_nettype wire
